// ===== mppb_top.v
// Motion profile parameter bank: object store, jerk select, setpoint offsets
`timescale 1ns/10ps
`include "mppb_consts.vh"

module mppb_top #(
  parameter PW = 32,
  parameter TW = 16
) (
  // Clock and reset
  input  wire          SYS_CLK,
  input  wire          RST_N,
  // Object access port
  input  wire          OD_WR,
  input  wire          OD_RD,
  input  wire [15:0]   OD_INDEX,
  input  wire [7:0]    OD_SUBINDEX,
  input  wire [31:0]   OD_WDATA,
  output reg  [31:0]   OD_RDATA,
  output reg           OD_ACK,
  output reg           OD_ERR,
  // Ramp generator interface
  input  wire [1:0]    RAMP_SEG,
  output wire [31:0]   RAMP_JERK,
  output wire          RAMP_JERK_UNLIM,
  // Operating mode and raw setpoints
  input  wire [7:0]    OP_MODE,
  input  wire [PW-1:0] POS_SETPT,
  input  wire [PW-1:0] SPD_SETPT,
  input  wire [TW-1:0] TRQ_SETPT,
  // Offset-adjusted setpoints
  output wire [PW-1:0] POS_DEMAND,
  output wire [PW-1:0] SPD_DEMAND,
  output wire [TW-1:0] TRQ_DEMAND,
  // Interpolation setpoint path
  input  wire          IP_SETPT_VALID,
  input  wire [31:0]   IP_SETPT,
  input  wire          SYNC_PULSE,
  output reg  [31:0]   IP_DEMAND_POS,
  // Unit words for conversion logic
  output reg  [31:0]   POS_UNIT,
  output reg  [31:0]   SPD_UNIT
);

  // One jerk limit per ramp segment
  localparam JERK_N = `MPPB_JERK_SUBS;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  wire [31:0]   jerk_lim [0:JERK_N-1];
  reg  [PW-1:0] pos_offs_r;
  reg  [PW-1:0] spd_offs_r;
  reg  [TW-1:0] trq_offs_r;
  reg  [31:0]   ip_pend_r;
  reg           ip_pend_vld_r;

  reg  [31:0]   rdata_nxt;
  reg           hit_nxt;
  reg           wr_ok_nxt;

  wire          sub0;
  wire          sub1;
  wire [7:0]    jerk_ofs;
  wire [1:0]    jerk_idx;
  wire          jerk_wr;
  wire [JERK_N-1:0] jerk_we;

  assign sub0 = (OD_SUBINDEX == `MPPB_SUB_COUNT);
  assign sub1 = (OD_SUBINDEX == `MPPB_SUB_FIRST);

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  // hit_nxt: object/subindex exists; wr_ok_nxt: it accepts writes
  always @* begin
    rdata_nxt = 32'h00000000;
    hit_nxt   = 1'b0;
    wr_ok_nxt = 1'b0;
    case (OD_INDEX)
      `MPPB_IDX_JERK: begin
        case (OD_SUBINDEX)
          `MPPB_SUB_COUNT: begin
            rdata_nxt = `MPPB_JERK_SUBS;
            hit_nxt   = 1'b1;
          end
          `MPPB_SUB_BEG_ACC: begin
            rdata_nxt = jerk_lim[`MPPB_SEG_BEG_ACC];
            hit_nxt   = 1'b1;
            wr_ok_nxt = 1'b1;
          end
          `MPPB_SUB_BEG_DEC: begin
            rdata_nxt = jerk_lim[`MPPB_SEG_BEG_DEC];
            hit_nxt   = 1'b1;
            wr_ok_nxt = 1'b1;
          end
          `MPPB_SUB_END_ACC: begin
            rdata_nxt = jerk_lim[`MPPB_SEG_END_ACC];
            hit_nxt   = 1'b1;
            wr_ok_nxt = 1'b1;
          end
          `MPPB_SUB_END_DEC: begin
            rdata_nxt = jerk_lim[`MPPB_SEG_END_DEC];
            hit_nxt   = 1'b1;
            wr_ok_nxt = 1'b1;
          end
          default: begin
            rdata_nxt = 32'h00000000;
          end
        endcase
      end
      `MPPB_IDX_POS_UNIT: begin
        rdata_nxt = POS_UNIT & `MPPB_POS_UNIT_MASK;
        hit_nxt   = sub0;
        wr_ok_nxt = sub0;
      end
      `MPPB_IDX_SPD_UNIT: begin
        rdata_nxt = SPD_UNIT & `MPPB_SPD_UNIT_MASK;
        hit_nxt   = sub0;
        wr_ok_nxt = sub0;
      end
      `MPPB_IDX_POS_OFFS: begin
        rdata_nxt = pos_offs_r;
        hit_nxt   = sub0;
        wr_ok_nxt = sub0;
      end
      `MPPB_IDX_SPD_OFFS: begin
        rdata_nxt = spd_offs_r;
        hit_nxt   = sub0;
        wr_ok_nxt = sub0;
      end
      `MPPB_IDX_TRQ_OFFS: begin
        // Narrow object sits in the low half, upper half reads zero
        rdata_nxt = {16'h0000, trq_offs_r};
        hit_nxt   = sub0;
        wr_ok_nxt = sub0;
      end
      `MPPB_IDX_INTERP: begin
        if (sub0) begin
          rdata_nxt = `MPPB_INTERP_SUBS;
        end else begin
          rdata_nxt = IP_DEMAND_POS;
        end
        hit_nxt   = sub0 | sub1;
        wr_ok_nxt = 1'b0;
      end
      default: begin
        rdata_nxt = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Access response
  // ----------------------------------------------------------------
  // Each strobe gets one ack pulse a cycle later; refused access adds err
  // Write wins when both strobes are high; read data holds between reads
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      OD_RDATA <= 32'h00000000;
      OD_ACK   <= 1'b0;
      OD_ERR   <= 1'b0;
    end else begin
      OD_ACK <= OD_WR | OD_RD;
      if (OD_WR) begin
        OD_ERR <= ~wr_ok_nxt;
      end else if (OD_RD) begin
        OD_ERR <= ~hit_nxt;
      end else begin
        OD_ERR <= 1'b0;
      end
      if (OD_RD && !OD_WR && hit_nxt) begin
        OD_RDATA <= rdata_nxt;
      end else if (OD_RD && !OD_WR) begin
        OD_RDATA <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Parameter writes
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      POS_UNIT       <= `MPPB_POS_UNIT_RST;
      SPD_UNIT       <= `MPPB_SPD_UNIT_RST;
      pos_offs_r     <= `MPPB_OFFS_RST;
      spd_offs_r     <= `MPPB_OFFS_RST;
      trq_offs_r     <= `MPPB_TRQ_RST;
    end else if (OD_WR && wr_ok_nxt) begin
      // Jerk limits are written in their own per-entry store below
      case (OD_INDEX)
        `MPPB_IDX_POS_UNIT: POS_UNIT   <= OD_WDATA & `MPPB_POS_UNIT_MASK;
        `MPPB_IDX_SPD_UNIT: SPD_UNIT   <= OD_WDATA & `MPPB_SPD_UNIT_MASK;
        `MPPB_IDX_POS_OFFS: pos_offs_r <= OD_WDATA;
        `MPPB_IDX_SPD_OFFS: spd_offs_r <= OD_WDATA;
        `MPPB_IDX_TRQ_OFFS: trq_offs_r <= OD_WDATA[`MPPB_TRQ_MSB:`MPPB_TRQ_LSB];
        default:            pos_offs_r <= pos_offs_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Jerk limits, one entry per ramp segment
  // ----------------------------------------------------------------
  // Entries follow the segment codes, so subindex minus one addresses
  // the same entry that the ramp generator selects.
  assign jerk_ofs = OD_SUBINDEX - `MPPB_SUB_FIRST;
  assign jerk_idx = jerk_ofs[1:0];
  assign jerk_wr  = OD_WR && wr_ok_nxt && (OD_INDEX == `MPPB_IDX_JERK);
  assign jerk_we  = jerk_wr ? ({{(JERK_N-1){1'b0}}, 1'b1} << jerk_idx) : {JERK_N{1'b0}};

  genvar g;
  generate
    for (g = 0; g < JERK_N; g = g + 1) begin : g_jerk
      reg [31:0] lim_r;
      always @(posedge SYS_CLK) begin
        if (!RST_N) begin
          lim_r <= `MPPB_JERK_RST;
        end else if (jerk_we[g]) begin
          lim_r <= OD_WDATA;
        end
      end
      assign jerk_lim[g] = lim_r;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interpolation setpoint, taken over at sync
  // ----------------------------------------------------------------
  // A setpoint arriving together with sync waits for the following sync,
  // so the demand never changes between two sync instants.
  // The pending flag drops at sync so one value is never applied twice.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ip_pend_r     <= `MPPB_INTERP_RST;
      ip_pend_vld_r <= 1'b0;
      IP_DEMAND_POS <= `MPPB_INTERP_RST;
    end else begin
      if (SYNC_PULSE && ip_pend_vld_r) begin
        IP_DEMAND_POS <= ip_pend_r;
      end
      if (IP_SETPT_VALID) begin
        ip_pend_r     <= IP_SETPT;
        ip_pend_vld_r <= 1'b1;
      end else if (SYNC_PULSE) begin
        ip_pend_vld_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Ramp jerk selection
  // ----------------------------------------------------------------
  // The select is registered so the ramp generator sees a fixed latency
  mppb_jerk_sel #(
    .W (32)
  ) u_jerk (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .seg     (RAMP_SEG),
    .beg_acc (jerk_lim[`MPPB_SEG_BEG_ACC]),
    .beg_dec (jerk_lim[`MPPB_SEG_BEG_DEC]),
    .end_acc (jerk_lim[`MPPB_SEG_END_ACC]),
    .end_dec (jerk_lim[`MPPB_SEG_END_DEC]),
    .jerk_r  (RAMP_JERK),
    .unlim_r (RAMP_JERK_UNLIM)
  );

  // ----------------------------------------------------------------
  // Setpoint offsets
  // ----------------------------------------------------------------
  // Offsets are stored raw; the mode gate sits beside the adders
  mppb_setpt_offs #(
    .PW (PW),
    .TW (TW)
  ) u_offs (
    .clk      (SYS_CLK),
    .rst_n    (RST_N),
    .mode     (OP_MODE),
    .pos_in   (POS_SETPT),
    .spd_in   (SPD_SETPT),
    .trq_in   (TRQ_SETPT),
    .pos_offs (pos_offs_r),
    .spd_offs (spd_offs_r),
    .trq_offs (trq_offs_r),
    .pos_r    (POS_DEMAND),
    .spd_r    (SPD_DEMAND),
    .trq_r    (TRQ_DEMAND)
  );

endmodule // mppb_top

// ===== mppb_consts.vh
// Constants of the motion profile parameter bank
`ifndef MPPB_CONSTS_VH
`define MPPB_CONSTS_VH

// ----------------------------------------------------------------
// Object indexes
// ----------------------------------------------------------------
`define MPPB_IDX_JERK      16'h60A4
`define MPPB_IDX_POS_UNIT  16'h60A8
`define MPPB_IDX_SPD_UNIT  16'h60A9
`define MPPB_IDX_POS_OFFS  16'h60B0
`define MPPB_IDX_SPD_OFFS  16'h60B1
`define MPPB_IDX_TRQ_OFFS  16'h60B2
`define MPPB_IDX_INTERP    16'h60C1

// ----------------------------------------------------------------
// Subindexes
// ----------------------------------------------------------------
`define MPPB_SUB_COUNT     8'h00
`define MPPB_SUB_BEG_ACC   8'h01
`define MPPB_SUB_BEG_DEC   8'h02
`define MPPB_SUB_END_ACC   8'h03
`define MPPB_SUB_END_DEC   8'h04
`define MPPB_SUB_FIRST     8'h01
`define MPPB_JERK_SUBS     32'h00000004
`define MPPB_INTERP_SUBS   32'h00000001

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MPPB_JERK_RST      32'h000003E8
`define MPPB_POS_UNIT_RST  32'hFF410000
`define MPPB_SPD_UNIT_RST  32'h00B44700
`define MPPB_OFFS_RST      32'h00000000
`define MPPB_TRQ_RST       16'h0000
`define MPPB_INTERP_RST    32'h00000000

// ----------------------------------------------------------------
// Unit word fields: writable bits only, reserved bits stay zero
// ----------------------------------------------------------------
`define MPPB_POS_UNIT_MASK 32'hFFFF0000
`define MPPB_SPD_UNIT_MASK 32'hFFFFFF00
`define MPPB_TRQ_LSB       0
`define MPPB_TRQ_MSB       15

// ----------------------------------------------------------------
// Ramp segment codes
// ----------------------------------------------------------------
`define MPPB_SEG_BEG_ACC   2'h0
`define MPPB_SEG_BEG_DEC   2'h1
`define MPPB_SEG_END_ACC   2'h2
`define MPPB_SEG_END_DEC   2'h3

// ----------------------------------------------------------------
// Operating mode codes
// ----------------------------------------------------------------
`define MPPB_MODE_IP       8'h07
`define MPPB_MODE_CSP      8'h08
`define MPPB_MODE_CSV      8'h09
`define MPPB_MODE_CST      8'h0A
`define MPPB_MODE_STEPDIR  8'hFF

`endif

// ===== mppb_jerk_sel.v
// Jerk limit selector for the four ramp segments
`timescale 1ns/10ps
`include "mppb_consts.vh"

module mppb_jerk_sel #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // Segment request
  input  wire [1:0]   seg,
  // Limits
  input  wire [W-1:0] beg_acc,
  input  wire [W-1:0] beg_dec,
  input  wire [W-1:0] end_acc,
  input  wire [W-1:0] end_dec,
  // Result
  output reg  [W-1:0] jerk_r,
  output reg          unlim_r
);

  reg [W-1:0] jerk_nxt;

  // ----------------------------------------------------------------
  // Segment decode
  // ----------------------------------------------------------------
  always @* begin
    case (seg)
      `MPPB_SEG_BEG_ACC: jerk_nxt = beg_acc;
      `MPPB_SEG_BEG_DEC: jerk_nxt = beg_dec;
      `MPPB_SEG_END_ACC: jerk_nxt = end_acc;
      `MPPB_SEG_END_DEC: jerk_nxt = end_dec;
      default:           jerk_nxt = beg_acc;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      jerk_r  <= {W{1'b0}};
      unlim_r <= 1'b1;
    end else begin
      jerk_r  <= jerk_nxt;
      // Zero is no limit at all, not a frozen acceleration
      unlim_r <= (jerk_nxt == {W{1'b0}});
    end
  end

endmodule // mppb_jerk_sel

// ===== mppb_setpt_offs.v
// Setpoint offset adder gated by operating mode
`timescale 1ns/10ps
`include "mppb_consts.vh"

module mppb_setpt_offs #(
  parameter PW = 32,
  parameter TW = 16
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst_n,
  // Mode and setpoints
  input  wire [7:0]    mode,
  input  wire [PW-1:0] pos_in,
  input  wire [PW-1:0] spd_in,
  input  wire [TW-1:0] trq_in,
  // Offsets
  input  wire [PW-1:0] pos_offs,
  input  wire [PW-1:0] spd_offs,
  input  wire [TW-1:0] trq_offs,
  // Adjusted setpoints
  output reg  [PW-1:0] pos_r,
  output reg  [PW-1:0] spd_r,
  output reg  [TW-1:0] trq_r
);

  wire pos_en;
  wire spd_en;
  wire trq_en;

  // ----------------------------------------------------------------
  // Mode gating
  // ----------------------------------------------------------------
  assign pos_en = (mode == `MPPB_MODE_CSP) || (mode == `MPPB_MODE_STEPDIR);
  assign spd_en = pos_en || (mode == `MPPB_MODE_CSV);
  assign trq_en = spd_en || (mode == `MPPB_MODE_CST);

  // Two's complement sums wrap; saturation is left to the consumer
  always @(posedge clk) begin
    if (!rst_n) begin
      pos_r <= {PW{1'b0}};
      spd_r <= {PW{1'b0}};
      trq_r <= {TW{1'b0}};
    end else begin
      pos_r <= pos_en ? pos_in + pos_offs : pos_in;
      spd_r <= spd_en ? spd_in + spd_offs : spd_in;
      trq_r <= trq_en ? trq_in + trq_offs : trq_in;
    end
  end

endmodule // mppb_setpt_offs

// ===== mppb_top_monitor.sv
// Concurrent checks on the parameter bank ports
`timescale 1ns/10ps
`include "mppb_consts.vh"

module mppb_top_monitor #(
  parameter PW = 32,
  parameter TW = 16
) (
  // Clock and reset
  input wire          SYS_CLK,
  input wire          RST_N,
  // Object port
  input wire          OD_WR,
  input wire          OD_RD,
  input wire [15:0]   OD_INDEX,
  input wire          OD_ACK,
  input wire          OD_ERR,
  // Ramp
  input wire [31:0]   RAMP_JERK,
  input wire          RAMP_JERK_UNLIM,
  // Setpoints
  input wire [7:0]    OP_MODE,
  input wire [PW-1:0] POS_SETPT,
  input wire [PW-1:0] SPD_SETPT,
  input wire [TW-1:0] TRQ_SETPT,
  input wire [PW-1:0] POS_DEMAND,
  input wire [PW-1:0] SPD_DEMAND,
  input wire [TW-1:0] TRQ_DEMAND,
  // Interpolation and units
  input wire          SYNC_PULSE,
  input wire [31:0]   IP_DEMAND_POS,
  input wire [31:0]   POS_UNIT,
  input wire [31:0]   SPD_UNIT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire pos_on = (OP_MODE == `MPPB_MODE_CSP) || (OP_MODE == `MPPB_MODE_STEPDIR);
  wire spd_on = pos_on || (OP_MODE == `MPPB_MODE_CSV);
  wire trq_on = spd_on || (OP_MODE == `MPPB_MODE_CST);

  a_ack_one_cycle: assert property (OD_ACK == $past(OD_WR || OD_RD))
    else $error("Ack does not follow strobe by one cycle");
  a_ro_write_err: assert property (OD_WR && OD_INDEX == `MPPB_IDX_INTERP |=> OD_ACK && OD_ERR)
    else $error("Write to read-only record not refused");
  a_unlim_zero: assert property (RAMP_JERK_UNLIM == (RAMP_JERK == 32'h00000000))
    else $error("Unlimited flag disagrees with jerk value");
  a_pos_unit_rsvd: assert property (POS_UNIT[15:0] == 16'h0000)
    else $error("Position unit low half not zero");
  a_spd_unit_rsvd: assert property (SPD_UNIT[7:0] == 8'h00)
    else $error("Speed unit low byte not zero");
  a_pos_no_offs: assert property (!pos_on |=> POS_DEMAND == $past(POS_SETPT))
    else $error("Position offset applied in wrong mode");
  a_spd_no_offs: assert property (!spd_on |=> SPD_DEMAND == $past(SPD_SETPT))
    else $error("Speed offset applied in wrong mode");
  a_trq_no_offs: assert property (!trq_on |=> TRQ_DEMAND == $past(TRQ_SETPT))
    else $error("Torque offset applied in wrong mode");
  a_ip_sync_only: assert property ($changed(IP_DEMAND_POS) |-> $past(SYNC_PULSE))
    else $error("Demand position changed without sync");

  c_sync_update: cover property ($past(SYNC_PULSE) && $changed(IP_DEMAND_POS));
  c_unlimited: cover property (RAMP_JERK_UNLIM);
  c_refused: cover property (OD_ACK && OD_ERR);
endmodule // mppb_top_monitor

// ===== mppb_host_mdl.sv
// Host model issuing object reads and writes
`timescale 1ns/10ps

module mppb_host_mdl (
  // Clock
  input  wire        clk,
  // Request
  output reg         od_wr,
  output reg         od_rd,
  output reg  [15:0] od_index,
  output reg  [7:0]  od_subindex,
  output reg  [31:0] od_wdata,
  // Answer
  input  wire [31:0] od_rdata,
  input  wire        od_ack,
  input  wire        od_err
);
  initial begin
    od_wr = 1'b0;
    od_rd = 1'b0;
    od_index = 16'h0000;
    od_subindex = 8'h00;
    od_wdata = 32'h00000000;
  end

  task acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
           input logic [31:0] d, output logic [31:0] rdat, output logic err);
    begin
      @(posedge clk);
      od_wr <= w;
      od_rd <= !w;
      od_index <= idx;
      od_subindex <= sub;
      od_wdata <= d;
      @(posedge clk);
      od_wr <= 1'b0;
      od_rd <= 1'b0;
      // Released lines must not keep the last value
      od_index <= ~idx;
      od_subindex <= ~sub;
      od_wdata <= ~d;
      #1;
      rdat = od_rdata;
      // A missing ack shows up as an unknown error flag
      err = od_ack ? od_err : 1'bx;
    end
  endtask
endmodule // mppb_host_mdl

// ===== tb_top.sv
// Self-checking bench for the parameter bank
`timescale 1ns/10ps
`include "mppb_consts.vh"

module tb_top;
  reg         sys_clk;
  reg         rst_n;
  reg  [1:0]  ramp_seg;
  reg  [7:0]  op_mode;
  reg  [31:0] pos_setpt;
  reg  [31:0] spd_setpt;
  reg  [15:0] trq_setpt;
  reg         ip_valid;
  reg  [31:0] ip_setpt;
  reg         sync_pulse;
  wire        od_wr;
  wire        od_rd;
  wire [15:0] od_index;
  wire [7:0]  od_sub;
  wire [31:0] od_wdata;
  wire [31:0] od_rdata;
  wire        od_ack;
  wire        od_err;
  wire [31:0] jerk;
  wire        unlim;
  wire [31:0] pos_dem;
  wire [31:0] spd_dem;
  wire [15:0] trq_dem;
  wire [31:0] ip_dem;
  wire [31:0] pos_unit;
  wire [31:0] spd_unit;
  integer     err_total;
  integer     check_count;

  mppb_top mppb_top_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .OD_WR(od_wr), .OD_RD(od_rd),
    .OD_INDEX(od_index), .OD_SUBINDEX(od_sub), .OD_WDATA(od_wdata), .OD_RDATA(od_rdata),
    .OD_ACK(od_ack), .OD_ERR(od_err), .RAMP_SEG(ramp_seg), .RAMP_JERK(jerk),
    .RAMP_JERK_UNLIM(unlim), .OP_MODE(op_mode), .POS_SETPT(pos_setpt),
    .SPD_SETPT(spd_setpt), .TRQ_SETPT(trq_setpt), .POS_DEMAND(pos_dem),
    .SPD_DEMAND(spd_dem), .TRQ_DEMAND(trq_dem), .IP_SETPT_VALID(ip_valid),
    .IP_SETPT(ip_setpt), .SYNC_PULSE(sync_pulse), .IP_DEMAND_POS(ip_dem),
    .POS_UNIT(pos_unit), .SPD_UNIT(spd_unit));

  mppb_host_mdl mppb_host_mdl_i (.clk(sys_clk), .od_wr(od_wr), .od_rd(od_rd),
    .od_index(od_index), .od_subindex(od_sub), .od_wdata(od_wdata),
    .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task chk(input [8*8:1] nm, input logic [31:0] e, input logic [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
        err_total = err_total + 1;
      end
    end
  endtask

  task wr(input [15:0] i, input [7:0] s, input [31:0] d, input logic ee);
    logic [31:0] r;
    logic        e;
    begin
      mppb_host_mdl_i.acc(1'b1, i, s, d, r, e);
      chk("wr_err", {31'h0, ee}, {31'h0, e});
    end
  endtask

  task rd(input [15:0] i, input [7:0] s, input [31:0] x, input logic ee);
    logic [31:0] r;
    logic        e;
    begin
      mppb_host_mdl_i.acc(1'b0, i, s, 32'h00000000, r, e);
      chk("rd_err", {31'h0, ee}, {31'h0, e});
      chk("rdata", x, r);
    end
  endtask

  task t_reset_vals;
    integer i;
    begin
      rd(`MPPB_IDX_JERK, 8'h00, `MPPB_JERK_SUBS, 1'b0);
      for (i = 1; i < 5; i = i + 1)
        rd(`MPPB_IDX_JERK, i[7:0], 32'h000003E8, 1'b0);
      rd(`MPPB_IDX_POS_UNIT, 8'h00, 32'hFF410000, 1'b0);
      rd(`MPPB_IDX_SPD_UNIT, 8'h00, 32'h00B44700, 1'b0);
      rd(`MPPB_IDX_POS_OFFS, 8'h00, 32'h00000000, 1'b0);
      rd(`MPPB_IDX_SPD_OFFS, 8'h00, 32'h00000000, 1'b0);
      rd(`MPPB_IDX_TRQ_OFFS, 8'h00, 32'h00000000, 1'b0);
      rd(`MPPB_IDX_INTERP, 8'h00, `MPPB_INTERP_SUBS, 1'b0);
    end
  endtask

  task t_jerk;
    integer i;
    begin
      wr(`MPPB_IDX_JERK, 8'h00, 32'h00000009, 1'b1);
      for (i = 1; i < 5; i = i + 1)
        wr(`MPPB_IDX_JERK, i[7:0], 32'h00000100 + i, 1'b0);
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge sys_clk);
        ramp_seg <= i[1:0];
        @(posedge sys_clk);
        #1;
        chk("jerk", 32'h00000101 + i, jerk);
        chk("unlim", 32'h00000000, {31'h0, unlim});
      end
      wr(`MPPB_IDX_JERK, 8'h02, 32'h00000000, 1'b0);
      rd(`MPPB_IDX_JERK, 8'h02, 32'h00000000, 1'b0);
      @(posedge sys_clk);
      ramp_seg <= 2'h1;
      @(posedge sys_clk);
      #1;
      chk("unlim", 32'h00000001, {31'h0, unlim});
      @(posedge sys_clk);
      ramp_seg <= 2'h0;
      @(posedge sys_clk);
      #1;
      chk("jerk", 32'h00000101, jerk);
    end
  endtask

  task t_units;
    begin
      wr(`MPPB_IDX_POS_UNIT, 8'h00, 32'hFFFFFFFF, 1'b0);
      rd(`MPPB_IDX_POS_UNIT, 8'h00, 32'hFFFF0000, 1'b0);
      chk("pos_unit", 32'hFFFF0000, pos_unit);
      wr(`MPPB_IDX_SPD_UNIT, 8'h00, 32'hFFFFFFFF, 1'b0);
      rd(`MPPB_IDX_SPD_UNIT, 8'h00, 32'hFFFFFF00, 1'b0);
      chk("spd_unit", 32'hFFFFFF00, spd_unit);
    end
  endtask

  task t_offsets;
    logic [39:0] ml;
    logic [7:0]  m;
    logic        pe;
    logic        se;
    logic        te;
    integer      i;
    begin
      ml = 40'h0708090AFF;
      wr(`MPPB_IDX_POS_OFFS, 8'h00, 32'h00000010, 1'b0);
      wr(`MPPB_IDX_SPD_OFFS, 8'h00, 32'hFFFFFFFB, 1'b0);
      wr(`MPPB_IDX_TRQ_OFFS, 8'h00, 32'hABCD8003, 1'b0);
      rd(`MPPB_IDX_TRQ_OFFS, 8'h00, 32'h00008003, 1'b0);
      for (i = 0; i < 5; i = i + 1) begin
        m = ml[39 - 8 * i -: 8];
        pe = (m == 8'h08) || (m == 8'hFF);
        se = pe || (m == 8'h09);
        te = se || (m == 8'h0A);
        @(posedge sys_clk);
        op_mode <= m;
        @(posedge sys_clk);
        #1;
        chk("pos_dem", pe ? 32'h12345688 : 32'h12345678, pos_dem);
        chk("spd_dem", se ? 32'hFFFFFFFD : 32'h00000002, spd_dem);
        chk("trq_dem", {16'h0, te ? 16'h0002 : 16'h7FFF}, {16'h0, trq_dem});
      end
    end
  endtask

  task t_interp;
    begin
      wr(`MPPB_IDX_INTERP, 8'h01, 32'h00000055, 1'b1);
      rd(`MPPB_IDX_INTERP, 8'h01, 32'h00000000, 1'b0);
      rd(16'h6000, 8'h00, 32'h00000000, 1'b1);
      @(posedge sys_clk);
      ip_valid <= 1'b1;
      ip_setpt <= 32'hFFFFF000;
      @(posedge sys_clk);
      ip_valid <= 1'b0;
      ip_setpt <= 32'h00000FFF;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("ip_dem", 32'h00000000, ip_dem);
      @(posedge sys_clk);
      sync_pulse <= 1'b1;
      @(posedge sys_clk);
      sync_pulse <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("ip_dem", 32'hFFFFF000, ip_dem);
      rd(`MPPB_IDX_INTERP, 8'h01, 32'hFFFFF000, 1'b0);
      // Setpoint together with sync: nothing pending, so it waits a sync
      @(posedge sys_clk);
      ip_valid <= 1'b1;
      ip_setpt <= 32'h00000ABC;
      sync_pulse <= 1'b1;
      @(posedge sys_clk);
      ip_valid <= 1'b0;
      sync_pulse <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("ip_dem", 32'hFFFFF000, ip_dem);
      @(posedge sys_clk);
      sync_pulse <= 1'b1;
      @(posedge sys_clk);
      sync_pulse <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("ip_dem", 32'h00000ABC, ip_dem);
    end
  endtask

  task t_reset_again;
    begin
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset_vals;
      chk("ip_dem", 32'h00000000, ip_dem);
      chk("pos_unit", 32'hFF410000, pos_unit);
      chk("spd_unit", 32'h00B44700, spd_unit);
    end
  endtask

  task finish_test;
    begin
      $display("Mismatches %0d of %0d checks", err_total, check_count);
      if (err_total == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  initial begin
    #40000;
    err_total = err_total + 1;
    finish_test;
  end

  initial begin
    err_total = 0;
    check_count = 0;
    rst_n = 1'b0;
    ramp_seg = 2'h0;
    op_mode = 8'h07;
    pos_setpt = 32'h12345678;
    spd_setpt = 32'h00000002;
    trq_setpt = 16'h7FFF;
    ip_valid = 1'b0;
    ip_setpt = 32'h00000000;
    sync_pulse = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset_vals;
    t_jerk;
    t_units;
    t_offsets;
    t_interp;
    t_reset_again;
    finish_test;
  end
endmodule // tb_top

bind mppb_top mppb_top_monitor #(.PW(PW), .TW(TW)) mppb_top_monitor_i (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .OD_WR(OD_WR), .OD_RD(OD_RD), .OD_INDEX(OD_INDEX),
  .OD_ACK(OD_ACK), .OD_ERR(OD_ERR), .RAMP_JERK(RAMP_JERK), .RAMP_JERK_UNLIM(RAMP_JERK_UNLIM),
  .OP_MODE(OP_MODE), .POS_SETPT(POS_SETPT), .SPD_SETPT(SPD_SETPT), .TRQ_SETPT(TRQ_SETPT),
  .POS_DEMAND(POS_DEMAND), .SPD_DEMAND(SPD_DEMAND), .TRQ_DEMAND(TRQ_DEMAND),
  .SYNC_PULSE(SYNC_PULSE), .IP_DEMAND_POS(IP_DEMAND_POS), .POS_UNIT(POS_UNIT),
  .SPD_UNIT(SPD_UNIT));
